// ---- core/hpfc_pkg.sv ----
// Shared constants for the host port pause configuration block
package hpfc_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned STRB_W  = DATA_W / 8;
  // FIFO level word width
  localparam int unsigned LEVEL_W = 8;

  // Register byte address
  localparam logic [ADDR_W-1:0] PAUSE_CFG_OFF = 12'h1a8;

  // Field positions in the pause configuration register
  localparam int unsigned BIT_MANUAL = 0;
  localparam int unsigned BIT_TX_EN  = 1;
  localparam int unsigned BIT_RX_EN  = 2;
  localparam int unsigned BIT_CUR_TX = 3;
  localparam int unsigned BIT_CUR_RX = 4;
  localparam int unsigned BIT_CUR_DP = 5;
  localparam int unsigned BIT_BP_EN  = 6;
  localparam int unsigned BIT_HW_FC  = 7;
  localparam int unsigned FIELD_W    = 8;

  // Reset values
  localparam logic                HW_FC_RST   = 1'b0;
  localparam logic [DATA_W-1:0]   RDATA_RST   = 32'h0000_0000;
  localparam logic [LEVEL_W-1:0]  LEVEL_RST   = 8'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : hpfc_pkg

// ---- core/hpfc_reg_if.sv ----
`timescale 1ns/10ps
// Register access strobes between bus slave and register file
interface hpfc_reg_if;
  import hpfc_pkg::*;
  logic                wr_en;    // One-cycle write strobe
  logic [ADDR_W-1:0]   wr_addr;  // Write byte address
  logic [DATA_W-1:0]   wr_data;  // Write data
  logic [STRB_W-1:0]   wr_strb;  // Write byte enables
  logic                wr_ok;    // Write address is mapped
  logic                rd_en;    // One-cycle read strobe
  logic [ADDR_W-1:0]   rd_addr;  // Read byte address
  logic [DATA_W-1:0]   rd_data;  // Read data, same cycle
  logic                rd_ok;    // Read address is mapped
  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                input  wr_ok, rd_data, rd_ok);
  modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface : hpfc_reg_if

// ---- core/hpfc_axil_slave.sv ----
`timescale 1ns/10ps
// AXI4-Lite slave, one write and one read in flight
module hpfc_axil_slave
  import hpfc_pkg::*;
(
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_ce,
  input  wire logic [hpfc_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                        i_awvalid,
  output logic                             o_awready,
  input  wire logic [hpfc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic [hpfc_pkg::STRB_W-1:0] i_wstrb,
  input  wire logic                        i_wvalid,
  output logic                             o_wready,
  output logic [1:0]                       o_bresp,
  output logic                             o_bvalid,
  input  wire logic                        i_bready,
  input  wire logic [hpfc_pkg::ADDR_W-1:0] i_araddr,
  input  wire logic                        i_arvalid,
  output logic                             o_arready,
  output logic [hpfc_pkg::DATA_W-1:0]      o_rdata,
  output logic [1:0]                       o_rresp,
  output logic                             o_rvalid,
  input  wire logic                        i_rready,
  hpfc_reg_if.bus                          reg_bus
);
  import hpfc_pkg::*;

  logic [ADDR_W-1:0] aw_addr;   // Held write address
  logic [DATA_W-1:0] w_data;    // Held write data
  logic [STRB_W-1:0] w_strb;    // Held byte enables
  logic              aw_held;   // Address taken, not yet used
  logic              w_held;    // Data taken, not yet used

  // Handshake decode
  wire aw_take = i_ce && i_awvalid && o_awready;
  wire w_take  = i_ce && i_wvalid && o_wready;
  wire do_wr   = i_ce && aw_held && w_held && !o_bvalid;
  wire ar_take = i_ce && i_arvalid && o_arready;

  assign reg_bus.wr_en   = do_wr;
  assign reg_bus.wr_addr = aw_addr;
  assign reg_bus.wr_data = w_data;
  assign reg_bus.wr_strb = w_strb;
  assign reg_bus.rd_en   = ar_take;
  assign reg_bus.rd_addr = i_araddr;

  // Write channels and response
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr   <= '0;
      w_data    <= '0;
      w_strb    <= '0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= RESP_OKAY;
    end else if (i_ce) begin
      if (aw_take) begin
        aw_addr <= i_awaddr;
      end
      if (w_take) begin
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      aw_held   <= do_wr ? 1'b0 : (aw_held || aw_take);
      w_held    <= do_wr ? 1'b0 : (w_held || w_take);
      o_awready <= !(do_wr ? 1'b0 : (aw_held || aw_take));
      o_wready  <= !(do_wr ? 1'b0 : (w_held || w_take));
      if (do_wr) begin
        o_bvalid <= 1'b1;
        o_bresp  <= reg_bus.wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Read address and data
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= RDATA_RST;
      o_rresp   <= RESP_OKAY;
    end else if (i_ce) begin
      if (ar_take) begin
        o_rvalid  <= 1'b1;
        o_arready <= 1'b0;
        o_rdata   <= reg_bus.rd_data;
        o_rresp   <= reg_bus.rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end else if (!o_rvalid) begin
        o_arready <= 1'b1;
      end
    end
  end
endmodule : hpfc_axil_slave

// ---- core/hpfc_pause_resolve.sv ----
`timescale 1ns/10ps
// Resolves the pause and backpressure state in force on the host port
module hpfc_pause_resolve
  import hpfc_pkg::*;
(
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_ce,
  input  wire logic                         i_manual,
  input  wire logic                         i_rx_en,
  input  wire logic                         i_tx_en,
  input  wire logic                         i_bp_en,
  input  wire logic                         i_hw_fc,
  input  wire logic                         i_an_enable,
  input  wire logic                         i_an_rx_pause,
  input  wire logic                         i_an_tx_pause,
  input  wire logic                         i_half_duplex,
  input  wire logic [hpfc_pkg::LEVEL_W-1:0] i_mac_rx_level,
  input  wire logic [hpfc_pkg::LEVEL_W-1:0] i_swe_rx_level,
  output logic                              o_cur_rx,
  output logic                              o_cur_tx,
  output logic                              o_cur_dup,
  output logic                              o_backpressure,
  output logic [hpfc_pkg::LEVEL_W-1:0]      o_swe_tx_level,
  output logic [hpfc_pkg::LEVEL_W-1:0]      o_mac_tx_level
);
  import hpfc_pkg::*;

  wire use_bits = i_manual || !i_an_enable;
  wire sel_rx   = use_bits ? i_rx_en : i_an_rx_pause;
  wire sel_tx   = use_bits ? i_tx_en : i_an_tx_pause;
  wire next_rx  = !i_half_duplex && sel_rx;
  wire next_tx  = !i_half_duplex && sel_tx;
  wire next_bp  = i_half_duplex && i_bp_en;

  // Resolved state, frozen while clock enable is low
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cur_rx       <= 1'b0;
      o_cur_tx       <= 1'b0;
      o_cur_dup      <= 1'b0;
      o_backpressure <= 1'b0;
      o_swe_tx_level <= LEVEL_RST;
      o_mac_tx_level <= LEVEL_RST;
    end else if (i_ce) begin
      o_cur_rx       <= next_rx;
      o_cur_tx       <= next_tx;
      o_cur_dup      <= i_half_duplex;
      o_backpressure <= next_bp;
      o_swe_tx_level <= i_hw_fc ? i_mac_rx_level : LEVEL_RST;
      o_mac_tx_level <= i_hw_fc ? i_swe_rx_level : LEVEL_RST;
    end
  end
endmodule : hpfc_pause_resolve

// ---- core/hpfc_top.sv ----
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
module hpfc_top
  import hpfc_pkg::*;
(
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_ce,
  // AXI4-Lite slave
  input  wire logic [hpfc_pkg::ADDR_W-1:0]  i_awaddr,
  input  wire logic                         i_awvalid,
  output logic                              o_awready,
  input  wire logic [hpfc_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic [hpfc_pkg::STRB_W-1:0]  i_wstrb,
  input  wire logic                         i_wvalid,
  output logic                              o_wready,
  output logic [1:0]                        o_bresp,
  output logic                              o_bvalid,
  input  wire logic                         i_bready,
  input  wire logic [hpfc_pkg::ADDR_W-1:0]  i_araddr,
  input  wire logic                         i_arvalid,
  output logic                              o_arready,
  output logic [hpfc_pkg::DATA_W-1:0]       o_rdata,
  output logic [1:0]                        o_rresp,
  output logic                              o_rvalid,
  input  wire logic                         i_rready,
  // Configuration straps and loader rewrite strobe
  input  wire logic                         i_host_backpressure_strap,
  input  wire logic                         i_host_full_duplex_pause_strap,
  input  wire logic                         i_host_manual_pause_strap,
  input  wire logic                         i_strap_reload,
  // Virtual negotiation and port state
  input  wire logic                         i_an_enable,
  input  wire logic                         i_an_rx_pause,
  input  wire logic                         i_an_tx_pause,
  input  wire logic                         i_half_duplex,
  // FIFO levels
  input  wire logic [hpfc_pkg::LEVEL_W-1:0] i_mac_rx_level,
  input  wire logic [hpfc_pkg::LEVEL_W-1:0] i_swe_rx_level,
  output logic [hpfc_pkg::LEVEL_W-1:0]      o_swe_tx_level,
  output logic [hpfc_pkg::LEVEL_W-1:0]      o_mac_tx_level,
  // Resolved port controls
  output logic                              o_host_rx_pause_detect,
  output logic                              o_host_tx_pause_gen,
  output logic                              o_host_backpressure,
  output logic                              o_host_current_duplex
);
  import hpfc_pkg::*;

  // Writable fields and strap capture flag
  logic host_manual_pause_select;   // Manual select
  logic host_tx_pause_enable;       // Transmit pause enable
  logic host_rx_pause_enable;       // Receive pause enable
  logic host_backpressure_enable;   // Backpressure enable
  logic hardwired_fifo_pause;       // FIFO level cross-connect
  logic strap_done;                 // Straps captured since reset

  // Resolved state from the resolver
  logic cur_rx;                     // Detection in force
  logic cur_tx;                     // Generation in force
  logic cur_dup;                    // Actual duplex
  logic cur_bp;                     // Backpressure in force

  hpfc_reg_if reg_bus ();

  // Bus slave
  hpfc_axil_slave u_slave (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .reg_bus   (reg_bus.bus)
  );

  // Address decode
  wire wr_hit  = (reg_bus.wr_addr == PAUSE_CFG_OFF);
  wire rd_hit  = (reg_bus.rd_addr == PAUSE_CFG_OFF);
  wire wr_low  = reg_bus.wr_en && wr_hit && reg_bus.wr_strb[0];
  wire load    = !strap_done || i_strap_reload;
  assign reg_bus.wr_ok = wr_hit;
  assign reg_bus.rd_ok = rd_hit;

  wire next_manual = load ? i_host_manual_pause_strap
                   : (wr_low ? reg_bus.wr_data[BIT_MANUAL] : host_manual_pause_select);
  wire next_tx_en  = load ? i_host_full_duplex_pause_strap
                   : (wr_low ? reg_bus.wr_data[BIT_TX_EN] : host_tx_pause_enable);
  wire next_rx_en  = load ? i_host_full_duplex_pause_strap
                   : (wr_low ? reg_bus.wr_data[BIT_RX_EN] : host_rx_pause_enable);
  wire next_bp_en  = load ? i_host_backpressure_strap
                   : (wr_low ? reg_bus.wr_data[BIT_BP_EN] : host_backpressure_enable);
  wire next_hw_fc  = wr_low ? reg_bus.wr_data[BIT_HW_FC] : hardwired_fifo_pause;

  // Readback field word
  wire [FIELD_W-1:0] fields = {hardwired_fifo_pause, host_backpressure_enable,
                               cur_dup, cur_rx, cur_tx, host_rx_pause_enable,
                               host_tx_pause_enable, host_manual_pause_select};
  assign reg_bus.rd_data = rd_hit ? {{(DATA_W-FIELD_W){1'b0}}, fields} : RDATA_RST;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      host_manual_pause_select <= 1'b0;
      host_tx_pause_enable     <= 1'b0;
      host_rx_pause_enable     <= 1'b0;
      host_backpressure_enable <= 1'b0;
      hardwired_fifo_pause     <= HW_FC_RST;
      strap_done               <= 1'b0;
    end else if (i_ce) begin
      host_manual_pause_select <= next_manual;
      host_tx_pause_enable     <= next_tx_en;
      host_rx_pause_enable     <= next_rx_en;
      host_backpressure_enable <= next_bp_en;
      hardwired_fifo_pause     <= next_hw_fc;
      strap_done               <= 1'b1;
    end
  end

  hpfc_pause_resolve u_resolve (
    .i_mclk         (i_mclk),
    .i_rst_n        (i_rst_n),
    .i_ce           (i_ce),
    .i_manual       (host_manual_pause_select),
    .i_rx_en        (host_rx_pause_enable),
    .i_tx_en        (host_tx_pause_enable),
    .i_bp_en        (host_backpressure_enable),
    .i_hw_fc        (hardwired_fifo_pause),
    .i_an_enable    (i_an_enable),
    .i_an_rx_pause  (i_an_rx_pause),
    .i_an_tx_pause  (i_an_tx_pause),
    .i_half_duplex  (i_half_duplex),
    .i_mac_rx_level (i_mac_rx_level),
    .i_swe_rx_level (i_swe_rx_level),
    .o_cur_rx       (cur_rx),
    .o_cur_tx       (cur_tx),
    .o_cur_dup      (cur_dup),
    .o_backpressure (cur_bp),
    .o_swe_tx_level (o_swe_tx_level),
    .o_mac_tx_level (o_mac_tx_level)
  );

  assign o_host_rx_pause_detect = cur_rx;
  assign o_host_tx_pause_gen    = cur_tx;
  assign o_host_current_duplex  = cur_dup;
  assign o_host_backpressure    = cur_bp;

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  wire man_path = host_manual_pause_select || !i_an_enable;

  a_hw_route: assert property (i_ce && hardwired_fifo_pause |=>
    o_swe_tx_level == $past(i_mac_rx_level) && o_mac_tx_level == $past(i_swe_rx_level))
    else $error("fifo levels not cross-connected");
  a_hw_idle: assert property (i_ce && !hardwired_fifo_pause |=>
    o_swe_tx_level == LEVEL_RST && o_mac_tx_level == LEVEL_RST)
    else $error("fifo levels leak while hardwired off");
  a_bp_gen: assert property (i_ce |=>
    o_host_backpressure == $past(host_backpressure_enable && i_half_duplex))
    else $error("backpressure wrong");
  a_dup_report: assert property (i_ce ##1 !i_ce |=>
    o_host_current_duplex == $past(i_half_duplex, 2))
    else $error("duplex report not held or wrong");
  a_rx_manual: assert property (i_ce && man_path && !i_half_duplex |=>
    o_host_rx_pause_detect == $past(host_rx_pause_enable))
    else $error("receive pause not from enable bit");
  a_tx_manual: assert property (i_ce && man_path && !i_half_duplex |=>
    o_host_tx_pause_gen == $past(host_tx_pause_enable))
    else $error("transmit pause not from enable bit");
  a_an_path: assert property (i_rst_n && i_ce && !man_path && !i_half_duplex |=>
    o_host_rx_pause_detect == $past(i_an_rx_pause)
    && o_host_tx_pause_gen == $past(i_an_tx_pause))
    else $error("negotiated pause not applied");
  a_half_off: assert property (i_ce && i_half_duplex |=>
    !o_host_rx_pause_detect && !o_host_tx_pause_gen)
    else $error("pause active in half duplex");
  a_read_back: assert property (reg_bus.rd_en && rd_hit |->
    reg_bus.rd_data[BIT_CUR_RX] == cur_rx && reg_bus.rd_data[BIT_CUR_DP] == cur_dup)
    else $error("readback differs from state in force");
  a_strap_load: assert property (i_ce && i_strap_reload |=>
    host_manual_pause_select == $past(i_host_manual_pause_strap)
    && host_backpressure_enable == $past(i_host_backpressure_strap))
    else $error("strap rewrite not loaded");
  a_rsvd_zero: assert property (reg_bus.rd_data[DATA_W-1:FIELD_W] == '0)
    else $error("reserved bits not zero");

  c_hw_mode: cover property (i_ce && hardwired_fifo_pause ##1 i_ce);
  c_an_path: cover property (i_ce && !man_path && i_an_rx_pause && !i_half_duplex);
  c_half_bp: cover property (o_host_backpressure);
  c_reload:  cover property (i_ce && strap_done && i_strap_reload);
endmodule : hpfc_top

// ---- verif/hpfc_far_model.sv ----
`timescale 1ns/10ps
// Host MAC and switch engine receive FIFO levels, as seen by the block
module hpfc_far_model
  import hpfc_pkg::*;
(
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst_n,
  output logic [hpfc_pkg::LEVEL_W-1:0]      o_mac_rx_level,
  output logic [hpfc_pkg::LEVEL_W-1:0]      o_swe_rx_level
);
  import hpfc_pkg::*;
  logic [LEVEL_W-1:0] fill_cnt;  // Fill level, moves every cycle

  // levels change each cycle
  // Distinct moving levels so a crossed or stale path shows up
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fill_cnt <= LEVEL_RST;
    end else begin
      fill_cnt <= fill_cnt + 8'h01;
    end
  end

  // Switch engine side runs the inverse pattern
  assign o_mac_rx_level = fill_cnt;
  assign o_swe_rx_level = ~fill_cnt;
endmodule : hpfc_far_model

// ---- verif/tb_host_port_flow_control_select.sv ----
`timescale 1ns/10ps
// Register-level bench for the host port pause configuration block
module tb_host_port_flow_control_select;
  import hpfc_pkg::*;
  logic i_mclk = 1'b0, i_rst_n = 1'b0;               // Clock and reset
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;        // Bus addresses
  logic [DATA_W-1:0] wdata = '0, rdata;               // Bus data
  logic [STRB_W-1:0] wstrb = '0;                      // Byte enables
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0; // Write handshakes
  logic arvalid = 1'b0, rready = 1'b0;                // Read handshakes
  logic awready, wready, bvalid, arready, rvalid;     // Slave handshakes
  logic [1:0] bresp, rresp, resp;                     // Responses
  logic bp_strap = 1'b1, fd_strap = 1'b1, man_strap = 1'b0, reload = 1'b0;
  logic an_en = 1'b1, an_rx = 1'b0, an_tx = 1'b1, half = 1'b0, ce = 1'b1;
  logic [LEVEL_W-1:0] mac_lvl, swe_lvl, swe_tx, mac_tx; // FIFO levels
  logic rx_det, tx_gen, bp_out, dup_out;              // Resolved controls
  int fail_count = 0, n_tests = 0, cycles = 0;        // Tallies

  // Free-running clock, 100 ns period
  always #50 i_mclk = ~i_mclk;

  hpfc_top u_hpfc_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_host_backpressure_strap(bp_strap),
    .i_host_full_duplex_pause_strap(fd_strap), .i_host_manual_pause_strap(man_strap),
    .i_strap_reload(reload), .i_an_enable(an_en), .i_an_rx_pause(an_rx),
    .i_an_tx_pause(an_tx), .i_half_duplex(half), .i_mac_rx_level(mac_lvl),
    .i_swe_rx_level(swe_lvl), .o_swe_tx_level(swe_tx), .o_mac_tx_level(mac_tx),
    .o_host_rx_pause_detect(rx_det), .o_host_tx_pause_gen(tx_gen),
    .o_host_backpressure(bp_out), .o_host_current_duplex(dup_out));

  hpfc_far_model u_hpfc_far_model (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .o_mac_rx_level(mac_lvl), .o_swe_rx_level(swe_lvl));

  // Verdict and end of run
  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // One comparison, reported on mismatch
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk

  // Write cycle, entered just after a rising edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [STRB_W-1:0] s, input logic [1:0] exp_resp);
    logic aw_done, w_done, ra, rw, rb;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Hold each channel until its own ready is seen at an edge
    while (!(aw_done && w_done)) begin
      @(negedge i_mclk);
      ra = awready;
      rw = wready;
      @(posedge i_mclk);
      if (ra && !aw_done) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (rw && !w_done) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    bready <= 1'b1;
    do begin
      @(negedge i_mclk);
      rb = bvalid;
      resp = bresp;
      @(posedge i_mclk);
    end while (rb !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, exp_resp}, {30'h0, resp});
  endtask : wr

  // Read cycle with data and response compare
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                    input logic [1:0] exp_resp);
    logic ra, rv;
    logic [DATA_W-1:0] got;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge i_mclk);
      ra = arready;
      @(posedge i_mclk);
    end while (ra !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(negedge i_mclk);
      rv = rvalid;
      got = rdata;
      resp = rresp;
      @(posedge i_mclk);
    end while (rv !== 1'b1);
    rready <= 1'b0;
    chk("rdata", exp, got);
    chk("rresp", {30'h0, exp_resp}, {30'h0, resp});
  endtask : rd

  // Let registered status settle, then compare resolved controls
  task automatic pins(input logic [3:0] exp);
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("controls rx tx bp dup", {28'h0, exp}, {28'h0, rx_det, tx_gen, bp_out, dup_out});
    @(posedge i_mclk);
  endtask : pins

  // Hang guard
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      close_out();
    end
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    pins(4'b0100);
    rd(PAUSE_CFG_OFF, 32'h0000_004e, RESP_OKAY);
    // Manual path, read-only and reserved bits written as ones
    wr(PAUSE_CFG_OFF, 32'hffff_ff3d, 4'hf, RESP_OKAY);
    pins(4'b1000);
    rd(PAUSE_CFG_OFF, 32'h0000_0015, RESP_OKAY);
    // Negotiation off with manual clear uses the enable bits
    an_en <= 1'b0;
    wr(PAUSE_CFG_OFF, 32'h0000_0002, 4'hf, RESP_OKAY);
    pins(4'b0100);
    rd(PAUSE_CFG_OFF, 32'h0000_000a, RESP_OKAY);
    // Half duplex with and without backpressure
    half <= 1'b1;
    wr(PAUSE_CFG_OFF, 32'h0000_0047, 4'hf, RESP_OKAY);
    pins(4'b0011);
    rd(PAUSE_CFG_OFF, 32'h0000_0067, RESP_OKAY);
    wr(PAUSE_CFG_OFF, 32'h0000_0007, 4'hf, RESP_OKAY);
    pins(4'b0001);
    rd(PAUSE_CFG_OFF, 32'h0000_0027, RESP_OKAY);
    // Clock enable low freezes the reported duplex
    ce <= 1'b0;
    half <= 1'b0;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("frozen duplex", 32'h1, {31'h0, dup_out});
    @(posedge i_mclk);
    ce <= 1'b1;
    wr(PAUSE_CFG_OFF, 32'h0000_0081, 4'hf, RESP_OKAY);
    pins(4'b0000);
    @(negedge i_mclk);
    chk("swe tx level", {24'h0, mac_lvl - 8'h01}, {24'h0, swe_tx});
    chk("mac tx level", {24'h0, swe_lvl + 8'h01}, {24'h0, mac_tx});
    @(posedge i_mclk);
    wr(PAUSE_CFG_OFF, 32'h0000_0000, 4'hf, RESP_OKAY);
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("swe tx idle", 32'h0, {24'h0, swe_tx});
    chk("mac tx idle", 32'h0, {24'h0, mac_tx});
    @(posedge i_mclk);
    // Loader rewrites the straps
    bp_strap <= 1'b0;
    fd_strap <= 1'b0;
    man_strap <= 1'b1;
    wr(PAUSE_CFG_OFF, 32'h0000_0046, 4'hf, RESP_OKAY);
    reload <= 1'b1;
    @(posedge i_mclk);
    reload <= 1'b0;
    pins(4'b0000);
    rd(PAUSE_CFG_OFF, 32'h0000_0001, RESP_OKAY);
    // Disabled byte lane and unmapped neighbours
    wr(PAUSE_CFG_OFF, 32'h0000_00c6, 4'h0, RESP_OKAY);
    rd(PAUSE_CFG_OFF, 32'h0000_0001, RESP_OKAY);
    wr(12'h1ac, 32'h0000_00ff, 4'hf, RESP_SLVERR);
    rd(12'h1ac, 32'h0000_0000, RESP_SLVERR);
    rd(12'h1a4, 32'h0000_0000, RESP_SLVERR);
    rd(PAUSE_CFG_OFF, 32'h0000_0001, RESP_OKAY);
    // Second reset clears the hardwired bit, straps reload
    wr(PAUSE_CFG_OFF, 32'h0000_0081, 4'hf, RESP_OKAY);
    rd(PAUSE_CFG_OFF, 32'h0000_0081, RESP_OKAY);
    i_rst_n <= 1'b0;
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    rd(PAUSE_CFG_OFF, 32'h0000_0001, RESP_OKAY);
    pins(4'b0000);
    @(negedge i_mclk);
    chk("swe tx after reset", 32'h0, {24'h0, swe_tx});
    @(posedge i_mclk);
    close_out();
  end
endmodule : tb_host_port_flow_control_select
